/* hw/smcs_defs.svh */
// constants for the serial memory command sequencer: offsets, fields, resets, codes
`ifndef SMCS_DEFS_SVH
`define SMCS_DEFS_SVH

// register offsets (byte addresses)
`define SMCS_OFS_CTRL 8'h70
`define SMCS_OFS_STATUS 8'h74
`define SMCS_OFS_TXDATA 8'h78
`define SMCS_OFS_RXDATA 8'h7c
`define SMCS_OFS_OP1 8'h18
`define SMCS_OFS_ADDR1 8'h1c
`define SMCS_OFS_ALT1 8'h20
`define SMCS_OFS_LEN1 8'h24
`define SMCS_OFS_FMT1 8'h28
`define SMCS_OFS_OP2 8'h2c
`define SMCS_OFS_ADDR2 8'h30
`define SMCS_OFS_ALT2 8'h34
`define SMCS_OFS_LEN2 8'h38
`define SMCS_OFS_FMT2 8'h3c
`define SMCS_OFS_XOPS 8'h40
`define SMCS_OFS_XALT 8'h44
`define SMCS_OFS_XFMT 8'h48

// field positions
`define SMCS_OPCODE 7:0
`define SMCS_XIP_WOP 15:8
`define SMCS_XIP_ROP 7:0
`define SMCS_LEN 19:0
`define SMCS_FMT 21:0
`define SMCS_XFMT 20:0
`define SMCS_CTRL_SECOND_COMMAND_ENABLE 0
`define SMCS_CTRL_XIPE 1

// reset values
`define SMCS_WOP_RST 8'h02
`define SMCS_ROP_RST 8'h0b
`define SMCS_WORD_RST 32'h0
`define SMCS_LEN_RST 20'h0
`define SMCS_FMT_RST 22'h0

// lane mode codes
`define SMCS_MODE_OFF 3'h0
`define SMCS_MODE_SINGLE 3'h1
`define SMCS_MODE_DUAL 3'h2
`define SMCS_MODE_QUAD 3'h3
`define SMCS_MODE_QDDR 3'h7

// bits per byte, length code (bytes minus one) of one execute-in-place access
`define SMCS_BITS_BYTE 6'h08
`define SMCS_XIP_LEN 20'h3

`endif

/* hw/smcs_pin_sync.sv */
// three-stage synchronisers for the memory clock source and the data pins
`timescale 1ns/10ps
`default_nettype none
module smcs_pin_sync (
    input wire logic clock,
    input wire logic srst,
    input wire logic mclk_pin,
    input wire logic [3:0] dq_pin,
    output logic mclk_rise,
    output logic mclk_fall,
    output logic mclk_level,
    output logic [3:0] dq_level
);
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    logic [4:0] stable;

    // s1 feeds only s2; a change counts once s2 and s3 agree
    always_ff @(posedge clock) begin
        if (srst) begin
            s1 <= 5'h0;
            s2 <= 5'h0;
            s3 <= 5'h0;
        end else begin
            s1 <= {mclk_pin, dq_pin};
            s2 <= s1;
            s3 <= s2;
        end
    end

    // filtered levels, per bit
    always_ff @(posedge clock) begin
        if (srst) begin
            stable <= 5'h0;
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (s2[i] == s3[i]) begin
                    stable[i] <= s3[i];
                end
            end
        end
    end

    // edges of the filtered memory clock, one cycle each
    always_comb begin
        mclk_rise = (s2[4] == s3[4]) && s3[4] && !stable[4];
        mclk_fall = (s2[4] == s3[4]) && !s3[4] && stable[4];
        mclk_level = stable[4];
        dq_level = stable[3:0];
    end

endmodule : smcs_pin_sync
`default_nettype wire

/* hw/smcs_pkg.sv */
// types shared by the serial memory command sequencer
package smcs_pkg;

    // phase format, laid out exactly like the format registers [21:0]
    typedef struct packed {
        logic direction;
        logic [2:0] data_lane_mode;
        logic [4:0] dummy_cycle_count;
        logic [1:0] alt_byte_size;
        logic [2:0] alt_byte_lane_mode;
        logic [1:0] address_size;
        logic [2:0] address_lane_mode;
        logic [2:0] instruction_lane_mode;
    } smcs_fmt_t;

    // memory-side pins driven by the block
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic [3:0] dq_out;
        logic [3:0] dq_oe;
    } smcs_pins_t;

    // execute-in-place request from the system bus bridge
    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } smcs_xip_req_t;

    typedef enum logic [3:0] {
        ST_IDLE, ST_START, ST_INSTR, ST_ADDR, ST_ALT, ST_DUMMY, ST_DATA, ST_END, ST_GAP
    } smcs_state_t;

    typedef enum logic [1:0] {SEQ_FIRST, SEQ_SECOND, SEQ_XIP} smcs_seq_t;

endpackage : smcs_pkg

/* hw/smcs_sequencer.sv */
// serial memory command sequencer: registers, chained commands, execute-in-place
`timescale 1ns/10ps
`default_nettype none
`include "smcs_defs.svh"
module smcs_sequencer
    import smcs_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire smcs_xip_req_t xip_req,
    output logic xip_done,
    output logic [31:0] xip_rdata,
    input wire logic mclk_pin,
    input wire logic [3:0] dq_in,
    output smcs_pins_t pins
);
    // software-visible storage
    logic second_command_enable;
    logic xip_enable;
    logic [31:0] tx_data;
    logic [7:0] op1;
    logic [31:0] addr1;
    logic [31:0] alt1;
    logic [19:0] len1;
    smcs_fmt_t first_command_format;
    logic [7:0] second_command_opcode;
    logic [31:0] second_command_address;
    logic [31:0] second_command_alt_bytes;
    logic [19:0] second_command_length;
    smcs_fmt_t second_command_format;
    logic [7:0] xip_write_opcode;
    logic [7:0] xip_read_opcode;
    logic [31:0] xip_read_alt_bytes;
    logic [20:0] xip_read_format;

    // engine state
    smcs_state_t state;
    smcs_seq_t seq;
    smcs_fmt_t fmt;
    logic [7:0] op;
    logic [31:0] addr;
    logic [31:0] alt;
    logic [31:0] tx_word;
    logic [31:0] rx_word;
    logic [31:0] shreg;
    logic [5:0] bits_left;
    logic [20:0] bytes_left;
    logic [1:0] byte_idx;
    logic [7:0] done_count;

    logic mclk_rise;
    logic mclk_fall;
    logic mclk_level;
    logic [3:0] dq_level;

    smcs_pin_sync u_sync (
        .clock(clock),
        .srst(srst),
        .mclk_pin(mclk_pin),
        .dq_pin(dq_in),
        .mclk_rise(mclk_rise),
        .mclk_fall(mclk_fall),
        .mclk_level(mclk_level),
        .dq_level(dq_level)
    );

    // lanes per step for a mode code; reserved codes fall back to one lane
    function automatic logic [5:0] lanes(input logic [2:0] mode);
        case (mode)
            `SMCS_MODE_DUAL: lanes = 6'h2;
            `SMCS_MODE_QUAD, `SMCS_MODE_QDDR: lanes = 6'h4;
            default: lanes = 6'h1;
        endcase
    endfunction : lanes

    // lane mode that governs a phase
    function automatic logic [2:0] phase_mode(input smcs_state_t st, input smcs_fmt_t f);
        case (st)
            ST_INSTR: phase_mode = f.instruction_lane_mode;
            ST_ADDR: phase_mode = f.address_lane_mode;
            ST_ALT: phase_mode = f.alt_byte_lane_mode;
            ST_DATA: phase_mode = f.data_lane_mode;
            default: phase_mode = `SMCS_MODE_SINGLE;
        endcase
    endfunction : phase_mode

    // phase after st, skipping any with a zero mode or count
    function automatic smcs_state_t after(input smcs_state_t st, input smcs_fmt_t f);
        logic early;
        early = (st == ST_START) || (st == ST_INSTR);
        if (st == ST_START && f.instruction_lane_mode != `SMCS_MODE_OFF) begin
            after = ST_INSTR;
        end else if (early && f.address_lane_mode != `SMCS_MODE_OFF) begin
            after = ST_ADDR;
        end else if ((early || st == ST_ADDR) && f.alt_byte_lane_mode != `SMCS_MODE_OFF) begin
            after = ST_ALT;
        end else if (st != ST_DUMMY && st != ST_DATA && f.dummy_cycle_count != 5'h0) begin
            after = ST_DUMMY;
        end else if (st != ST_DATA && f.data_lane_mode != `SMCS_MODE_OFF) begin
            after = ST_DATA;
        end else begin
            after = ST_END;
        end
    endfunction : after

    // size code n carries n+1 bytes, sent most significant first
    function automatic logic [31:0] align(input logic [31:0] value, input logic [1:0] size);
        align = value << {2'h3 - size, 3'b000};
    endfunction : align

    function automatic logic [5:0] size_bits(input logic [1:0] size);
        size_bits = {({1'b0, size} + 3'h1), 3'b000};
    endfunction : size_bits

    // current step: lane width, whether this clock edge advances the phase
    logic [2:0] mode;
    logic [5:0] w;
    logic tick;
    logic reading;
    logic [3:0] lane_in;
    logic [31:0] next_sh;
    smcs_state_t next_state;
    logic [31:0] ent_sh;
    logic [5:0] ent_bits;
    logic last_step;

    always_comb begin
        mode = phase_mode(state, fmt);
        w = lanes(mode);
        // drive on the falling memory clock so the device samples on the rising one; QDDR phases other than dummy step on both edges
        tick = (mode == `SMCS_MODE_QDDR && state != ST_DUMMY) ? (mclk_rise || mclk_fall)
                                                               : mclk_fall;
        reading = (state == ST_DATA) && !fmt.direction;
        case (w)
            6'h1: lane_in = {3'h0, dq_level[1]};
            6'h2: lane_in = {2'h0, dq_level[1:0]};
            default: lane_in = dq_level;
        endcase
        if (!reading) begin
            lane_in = 4'h0;
        end
        next_sh = (shreg << w) | {28'h0, lane_in};
        last_step = (state == ST_DUMMY) ? (bits_left == 6'h1) : (bits_left == w);
        next_state = after(state, fmt);
        ent_sh = 32'h0;
        ent_bits = `SMCS_BITS_BYTE;
        case (next_state)
            ST_INSTR: ent_sh = {op, 24'h0};
            ST_ADDR: begin
                ent_sh = align(addr, fmt.address_size);
                ent_bits = size_bits(fmt.address_size);
            end
            ST_ALT: begin
                ent_sh = align(alt, fmt.alt_byte_size);
                ent_bits = size_bits(fmt.alt_byte_size);
            end
            ST_DUMMY: ent_bits = {1'b0, fmt.dummy_cycle_count};
            ST_DATA: ent_sh = {tx_word[7:0], 24'h0};
            default: ent_sh = 32'h0;
        endcase
    end

    logic wr_op1;
    assign wr_op1 = reg_write && reg_addr == `SMCS_OFS_OP1;

    // register writes
    always_ff @(posedge clock) begin
        if (srst) begin
            second_command_enable <= 1'b0;
            xip_enable <= 1'b0;
            tx_data <= `SMCS_WORD_RST;
            op1 <= 8'h0;
            addr1 <= `SMCS_WORD_RST;
            alt1 <= `SMCS_WORD_RST;
            len1 <= `SMCS_LEN_RST;
            first_command_format <= `SMCS_FMT_RST;
            second_command_opcode <= 8'h0;
            second_command_address <= `SMCS_WORD_RST;
            second_command_alt_bytes <= `SMCS_WORD_RST;
            second_command_length <= `SMCS_LEN_RST;
            second_command_format <= `SMCS_FMT_RST;
            xip_write_opcode <= `SMCS_WOP_RST;
            xip_read_opcode <= `SMCS_ROP_RST;
            xip_read_alt_bytes <= `SMCS_WORD_RST;
            xip_read_format <= 21'h0;
        end else if (reg_write) begin
            case (reg_addr)
                `SMCS_OFS_CTRL: begin
                    second_command_enable <= reg_wdata[`SMCS_CTRL_SECOND_COMMAND_ENABLE];
                    xip_enable <= reg_wdata[`SMCS_CTRL_XIPE];
                end
                `SMCS_OFS_TXDATA: tx_data <= reg_wdata;
                `SMCS_OFS_OP1: op1 <= reg_wdata[`SMCS_OPCODE];
                `SMCS_OFS_ADDR1: addr1 <= reg_wdata;
                `SMCS_OFS_ALT1: alt1 <= reg_wdata;
                `SMCS_OFS_LEN1: len1 <= reg_wdata[`SMCS_LEN];
                `SMCS_OFS_FMT1: first_command_format <= reg_wdata[`SMCS_FMT];
                `SMCS_OFS_OP2: second_command_opcode <= reg_wdata[`SMCS_OPCODE];
                `SMCS_OFS_ADDR2: second_command_address <= reg_wdata;
                `SMCS_OFS_ALT2: second_command_alt_bytes <= reg_wdata;
                `SMCS_OFS_LEN2: second_command_length <= reg_wdata[`SMCS_LEN];
                `SMCS_OFS_FMT2: second_command_format <= reg_wdata[`SMCS_FMT];
                `SMCS_OFS_XOPS: begin
                    xip_write_opcode <= reg_wdata[`SMCS_XIP_WOP];
                    xip_read_opcode <= reg_wdata[`SMCS_XIP_ROP];
                end
                `SMCS_OFS_XALT: xip_read_alt_bytes <= reg_wdata;
                `SMCS_OFS_XFMT: xip_read_format <= reg_wdata[`SMCS_XFMT];
                default: ;
            endcase
        end
    end

    // read data stands one cycle after the strobe; unmapped offsets read zero
    always_ff @(posedge clock) begin
        if (srst) begin
            reg_rdata <= 32'h0;
        end else if (reg_read) begin
            case (reg_addr)
                `SMCS_OFS_CTRL: reg_rdata <= {30'h0, xip_enable, second_command_enable};
                `SMCS_OFS_STATUS: reg_rdata <= {16'h0, done_count, 5'h0, seq,
                                                state != ST_IDLE};
                `SMCS_OFS_TXDATA: reg_rdata <= tx_data;
                `SMCS_OFS_RXDATA: reg_rdata <= rx_word;
                `SMCS_OFS_OP1: reg_rdata <= {24'h0, op1};
                `SMCS_OFS_ADDR1: reg_rdata <= addr1;
                `SMCS_OFS_ALT1: reg_rdata <= alt1;
                `SMCS_OFS_LEN1: reg_rdata <= {12'h0, len1};
                `SMCS_OFS_FMT1: reg_rdata <= {10'h0, first_command_format};
                `SMCS_OFS_OP2: reg_rdata <= {24'h0, second_command_opcode};
                `SMCS_OFS_ADDR2: reg_rdata <= second_command_address;
                `SMCS_OFS_ALT2: reg_rdata <= second_command_alt_bytes;
                `SMCS_OFS_LEN2: reg_rdata <= {12'h0, second_command_length};
                `SMCS_OFS_FMT2: reg_rdata <= {10'h0, second_command_format};
                `SMCS_OFS_XOPS: reg_rdata <= {16'h0, xip_write_opcode, xip_read_opcode};
                `SMCS_OFS_XALT: reg_rdata <= xip_read_alt_bytes;
                `SMCS_OFS_XFMT: reg_rdata <= {11'h0, xip_read_format};
                default: reg_rdata <= 32'h0;
            endcase
        end
    end

    // sequence engine; the command is snapshotted at launch so that register
    // writes during a transfer only affect the next one
    always_ff @(posedge clock) begin
        if (srst) begin
            state <= ST_IDLE;
            seq <= SEQ_FIRST;
            fmt <= `SMCS_FMT_RST;
            op <= 8'h0;
            addr <= 32'h0;
            alt <= 32'h0;
            tx_word <= 32'h0;
            rx_word <= 32'h0;
            shreg <= 32'h0;
            bits_left <= 6'h0;
            bytes_left <= 21'h0;
            byte_idx <= 2'h0;
            done_count <= 8'h0;
            xip_done <= 1'b0;
            pins <= '{sclk: 1'b0, cs_n: 1'b1, dq_out: 4'h0, dq_oe: 4'h0};
        end else begin
            xip_done <= 1'b0;
            // the end step keeps the clock up to its own step so the frame's last bit
            // still gets a rising edge; it drops together with chip select
            pins.sclk <= (state > ST_START && (state < ST_END || (state == ST_END && !tick)))
                         ? mclk_level : 1'b0;
            case (state)
                ST_IDLE: begin
                    if (wr_op1) begin
                        state <= ST_START;
                        seq <= SEQ_FIRST;
                        fmt <= first_command_format;
                        op <= reg_wdata[`SMCS_OPCODE];
                        addr <= addr1;
                        alt <= alt1;
                        tx_word <= tx_data;
                        bytes_left <= {1'b0, len1} + 21'h1;
                        pins.cs_n <= 1'b0;
                    end else if (xip_enable && xip_req.valid && !xip_done) begin
                        // a request still standing while done shows is the one just served
                        state <= ST_START;
                        seq <= SEQ_XIP;
                        // writes reuse the read phase format with the direction forced
                        fmt <= {xip_req.write, xip_read_format};
                        op <= xip_req.write ? xip_write_opcode : xip_read_opcode;
                        addr <= xip_req.addr;
                        alt <= xip_read_alt_bytes;
                        tx_word <= xip_req.wdata;
                        bytes_left <= {1'b0, `SMCS_XIP_LEN} + 21'h1;
                        pins.cs_n <= 1'b0;
                    end
                end
                ST_START: begin
                    if (tick) begin
                        state <= next_state;
                        shreg <= ent_sh;
                        bits_left <= ent_bits;
                        byte_idx <= 2'h0;
                    end
                end
                ST_INSTR, ST_ADDR, ST_ALT, ST_DATA: begin
                    if (tick) begin
                        pins.dq_out <= (w == 6'h1) ? {3'h0, shreg[31]} :
                                       (w == 6'h2) ? {2'h0, shreg[31:30]} : shreg[31:28];
                        pins.dq_oe <= reading ? 4'h0 : (w == 6'h1) ? 4'h1 :
                                      (w == 6'h2) ? 4'h3 : 4'hf;
                        shreg <= next_sh;
                        bits_left <= bits_left - w;
                        if (last_step && state == ST_DATA) begin
                            if (reading) begin
                                rx_word[{byte_idx, 3'b000} +: 8] <= next_sh[7:0];
                            end
                            byte_idx <= byte_idx + 2'h1;
                            bytes_left <= bytes_left - 21'h1;
                        end
                        if (last_step && state == ST_DATA && bytes_left != 21'h1) begin
                            // next byte of the data word, lowest byte first
                            shreg <= {tx_word[{byte_idx + 2'h1, 3'b000} +: 8], 24'h0};
                            bits_left <= `SMCS_BITS_BYTE;
                        end else if (last_step) begin
                            state <= next_state;
                            shreg <= ent_sh;
                            bits_left <= ent_bits;
                        end
                    end
                end
                ST_DUMMY: begin
                    if (tick) begin
                        // release only at a step, after the previous bit had its rising clock
                        pins.dq_oe <= 4'h0;
                        bits_left <= bits_left - 6'h1;
                        if (last_step) begin
                            state <= next_state;
                            shreg <= ent_sh;
                            bits_left <= ent_bits;
                        end
                    end
                end
                ST_END: begin
                    if (tick) begin
                        pins.cs_n <= 1'b1;
                        pins.dq_oe <= 4'h0;
                        done_count <= done_count + 8'h1;
                        xip_done <= seq == SEQ_XIP;
                        // the second sequence only ever follows a first one
                        state <= (seq == SEQ_FIRST && second_command_enable) ? ST_GAP
                                                                            : ST_IDLE;
                    end
                end
                ST_GAP: begin
                    if (tick) begin
                        state <= ST_START;
                        seq <= SEQ_SECOND;
                        fmt <= second_command_format;
                        op <= second_command_opcode;
                        addr <= second_command_address;
                        alt <= second_command_alt_bytes;
                        tx_word <= tx_data;
                        bytes_left <= {1'b0, second_command_length} + 21'h1;
                        pins.cs_n <= 1'b0;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    assign xip_rdata = rx_word;

endmodule : smcs_sequencer
`default_nettype wire

/* sim/smcs_mem_model.sv */
// behavioural serial memory: records driven bits, answers with a moving pattern
`timescale 1ns/10ps
`default_nettype none
module smcs_mem_model
    import smcs_pkg::*;
(
    input wire smcs_pins_t pins,
    output logic [3:0] dq_in,
    output logic [63:0] cap,
    output int nbits
);
    logic last = 1'b0;
    // each select starts a fresh record and a fresh pattern, so read data is fixed per frame
    always @(negedge pins.cs_n) begin
        cap = 64'h0;
        nbits = 0;
        last = 1'b0;
    end
    // memory samples lane 0 on the rising clock, only while the block drives it
    always @(posedge pins.sclk) begin
        if (!pins.cs_n && pins.dq_oe[0]) begin
            cap = {cap[62:0], pins.dq_out[0]};
            nbits++;
        end
    end
    // pattern moves every falling clock; deselected lines show the inverse of the held pattern value
    always @(negedge pins.sclk) begin
        if (!pins.cs_n) begin
            last = ~last;
        end
    end
    assign dq_in = pins.cs_n ? {4{~last}} : {4{last}};
endmodule : smcs_mem_model
`default_nettype wire

/* sim/smcs_sequencer_asserts.sv */
// port checker for the serial memory command sequencer
`timescale 1ns/10ps
`default_nettype none
module smcs_sequencer_asserts
    import smcs_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire smcs_xip_req_t xip_req,
    input wire logic xip_done,
    input wire logic [31:0] xip_rdata,
    input wire logic mclk_pin,
    input wire logic [3:0] dq_in,
    input wire smcs_pins_t pins
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    // reset must silence the pins whatever was running
    reset_quiet_a: assert property (disable iff (1'b0)
        srst |=> pins.cs_n && !pins.sclk && pins.dq_oe == 4'h0 && !xip_done) else $error("pins not quiet");
    op_start_a: assert property (
        reg_write && reg_addr == 8'h18 && pins.cs_n |=> !pins.cs_n) else $error("no start");
    done_rise_a: assert property (
        xip_done |-> $rose(pins.cs_n)) else $error("done off frame end");
    done_pulse_a: assert property (xip_done |=> !xip_done) else $error("done too long");
    // a deselected memory must see neither clock nor driven lanes
    oe_idle_a: assert property (
        pins.cs_n |-> pins.dq_oe == 4'h0 && !pins.sclk) else $error("pins busy while idle");
    frame_min_a: assert property (
        $fell(pins.cs_n) |=> !pins.cs_n [*8]) else $error("frame too short");
    rdata_hold_a: assert property (!reg_read |=> $stable(reg_rdata)) else $error("rdata moved");
    unmapped_zero_a: assert property (
        reg_read && reg_addr == 8'h04 |=> reg_rdata == 32'h0) else $error("unmapped not zero");
endmodule : smcs_sequencer_asserts
bind smcs_sequencer smcs_sequencer_asserts smcs_sequencer_asserts_inst (.clock, .srst, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .xip_req, .xip_done, .xip_rdata, .mclk_pin,
    .dq_in, .pins);
`default_nettype wire

/* sim/test_serial_memory_command_sequencer.sv */
// self-checking bench for the serial memory command sequencer
`timescale 1ns/10ps
`default_nettype none
`include "smcs_defs.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch %s expected %h seen %h", n, e, g); end end
module test_serial_memory_command_sequencer
    import smcs_pkg::*;
;
    logic clock = 1'b0, srst = 1'b1, mclk_pin = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, xip_rdata;
    logic xip_done;
    logic [3:0] dq_in;
    smcs_xip_req_t xip_req = '0;
    smcs_pins_t pins;
    logic [63:0] cap;
    int nbits, err_total = 0, samples_checked = 0;
    always #2 clock = ~clock;
    // link clock runs free with an odd phase offset to the block clock
    initial begin
        #0.7;
        forever #80 mclk_pin = ~mclk_pin;
    end
    smcs_sequencer smcs_sequencer_inst (.clock, .srst, .reg_addr, .reg_wdata, .reg_write,
        .reg_read, .reg_rdata, .xip_req, .xip_done, .xip_rdata, .mclk_pin, .dq_in, .pins);
    smcs_mem_model smcs_mem_model_inst (.pins, .dq_in, .cap, .nbits);
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr
    // read data stands from the cycle after the strobe until the next read
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        `CHK("reg_rdata", e, reg_rdata)
    endtask : rd
    task automatic wait_cs(input logic lvl);
        int n;
        n = 0;
        while (pins.cs_n !== lvl) begin
            @(posedge clock);
            #1;
            n++;
            if (n > 6000) begin
                err_total++;
                $display("mismatch cs_n expected %h seen %h", lvl, pins.cs_n);
                tally_and_finish();
            end
        end
    endtask : wait_cs
    task automatic frame(input int nb, input logic [63:0] c);
        wait_cs(1'b0);
        wait_cs(1'b1);
        `CHK("bit count", nb, nbits)
        `CHK("captured bits", c, cap)
    endtask : frame
    // reset values, unmapped offset last
    task automatic t_resets;
        logic [7:0] ofs [9] = '{8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c, 8'h40, 8'h44, 8'h48, 8'h04};
        for (int i = 0; i < 9; i++) begin
            rd(ofs[i], ofs[i] == 8'h40 ? {16'h0, `SMCS_WOP_RST, `SMCS_ROP_RST} : 32'h0);
        end
    endtask : t_resets
    // all-ones writes show the length and format field widths
    task automatic t_fields;
        wr(`SMCS_OFS_LEN2, 32'hffffffff);
        rd(`SMCS_OFS_LEN2, 32'h000fffff);
        wr(`SMCS_OFS_FMT2, 32'hffffffff);
        rd(`SMCS_OFS_FMT2, 32'h003fffff);
        wr(`SMCS_OFS_XFMT, 32'hffffffff);
        rd(`SMCS_OFS_XFMT, 32'h001fffff);
    endtask : t_fields
    task automatic t_first;
        wr(`SMCS_OFS_FMT1, 32'h1);
        wr(`SMCS_OFS_OP1, 32'h9f);
        frame(8, 64'h9f);
    endtask : t_first
    // second sequence rides directly behind a first one when enabled
    task automatic t_chain;
        wr(`SMCS_OFS_CTRL, 32'h1);
        wr(`SMCS_OFS_OP2, 32'h66);
        wr(`SMCS_OFS_ADDR2, 32'h1234abcd);
        wr(`SMCS_OFS_ALT2, 32'h55);
        wr(`SMCS_OFS_LEN2, 32'h1);
        wr(`SMCS_OFS_TXDATA, 32'hc3e1);
        wr(`SMCS_OFS_FMT2, 32'h00240149);
        wr(`SMCS_OFS_OP1, 32'h9f);
        frame(8, 64'h9f);
        frame(48, 64'h66abcd55e1c3);
        wr(`SMCS_OFS_CTRL, 32'h0);
    endtask : t_chain
    task automatic xip(input logic w, input logic [31:0] d, input int nb, input logic [63:0] c);
        int n;
        n = 0;
        @(posedge clock);
        xip_req <= '{valid: 1'b1, write: w, addr: 32'h100, wdata: d};
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (xip_done !== 1'b1 && n < 6000);
        if (n >= 6000) begin
            err_total++;
            $display("mismatch xip_done expected 1 seen %h", xip_done);
            tally_and_finish();
        end
        @(posedge clock);
        xip_req.valid <= 1'b0;
        `CHK("bit count", nb, nbits)
        `CHK("captured bits", c, cap)
    endtask : xip
    task automatic t_xip;
        wr(`SMCS_OFS_XALT, 32'h77);
        wr(`SMCS_OFS_XFMT, 32'h00040101);
        wr(`SMCS_OFS_CTRL, 32'h2);
        xip(1'b0, 32'h0, 16, 64'h0b77);
        // sixteen clocks precede the data, so each read byte is the pattern 0101 0101
        `CHK("xip_rdata", 32'h55555555, xip_rdata)
        rd(`SMCS_OFS_RXDATA, 32'h55555555);
        xip(1'b1, 32'h44332211, 48, 64'h027711223344);
    endtask : t_xip
    initial begin
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        t_resets();
        t_fields();
        t_first();
        t_chain();
        t_xip();
        tally_and_finish();
    end
endmodule : test_serial_memory_command_sequencer
`default_nettype wire
